/* File: include/freq_vin_on_defines.svh */
// constants for the switching-frequency and turn-on threshold block
// assumes a word-wide command port driven by the serial-bus front end
`ifndef FREQ_VIN_ON_DEFINES_SVH
`define FREQ_VIN_ON_DEFINES_SVH
`define CMD_FLOOR        8'h2B
`define CMD_FREQ         8'h33
`define CMD_TURN_ON      8'h35
`define CMD_STORE_ALL    8'h15
`define CMD_RESTORE_ALL  8'h16
`define TURN_ON_EXP_RST  5'h1E
`define TURN_ON_MIN_QV   16'h000A
`define TURN_ON_MAX_QV   16'h0049
`define FREQ_MIN_KHZ     16'h0000
`define FREQ_MAX_KHZ     16'h0672
`define FREQ_MAN_MAX     32'sh000003FF
`endif

/* File: include/freq_vin_on_pkg.sv */
// types shared by the frequency and turn-on threshold block
// assumes nothing beyond the defines header
package freq_vin_on_pkg;
  typedef logic [15:0] lin_word_t;
  typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_RUN} cfg_state_t;
endpackage : freq_vin_on_pkg

/* File: hdl/freq_and_vin_on_config.sv */
// configuration logic: switching frequency, turn-on threshold, floor check
// assumes a command front end delivering whole words on ref_clk
`timescale 1ns/10ps
`include "freq_vin_on_defines.svh"
module freq_and_vin_on_config
  import freq_vin_on_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // command port from the serial-bus front end
  input  wire logic        cmd_wr,
  input  wire logic        cmd_rd,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [15:0] cmd_wdata,
  output logic      [15:0] cmd_rdata,
  output logic             cmd_invalid,
  output logic             host_alert,
  // nonvolatile image and limits
  input  wire logic [15:0] nvm_freq,
  input  wire logic [15:0] nvm_turn_on,
  input  wire logic [15:0] ceiling_min,
  input  wire logic [15:0] ceiling_max,
  // converter status
  input  wire logic        conv_enable,
  input  wire logic        input_above_on,
  input  wire logic        low_input_raw,
  // hardware settings
  output logic      [10:0] freq_eff_khz,
  output logic      [15:0] turn_on_qv,
  output logic             low_input_fault
);
  // decode a linear word into an integer, fraction dropped (rounds down)
  // linear decode
  function automatic logic [31:0] lin_decode(input lin_word_t w);
    logic signed [4:0]  e;
    logic signed [31:0] m;
    begin
      e = $signed(w[15:11]);
      m = {{21{w[10]}}, w[10:0]};
      if (e < 0)
        lin_decode = 32'(m >>> (-e));
      else
        lin_decode = 32'(m <<< e);
    end
  endfunction : lin_decode

  // band table for the effective frequency
  function automatic logic [10:0] freq_map(input logic [31:0] f);
    begin
      if ($signed(f) < 250)       freq_map = 11'd225;
      else if (f < 300)           freq_map = 11'd275;
      else if (f < 350)           freq_map = 11'd325;
      else if (f < 410)           freq_map = 11'd375;
      else if (f < 500)           freq_map = 11'd450;
      else if (f < 600)           freq_map = 11'd550;
      else if (f < 700)           freq_map = 11'd650;
      else if (f < 820)           freq_map = 11'd750;
      else if (f < 1000)          freq_map = 11'd900;
      else if (f < 1200)          freq_map = 11'd1100;
      else if (f < 1400)          freq_map = 11'd1300;
      else                        freq_map = 11'd1500;
    end
  endfunction : freq_map

  // threshold in quarter volts, rounded down to a step and clamped
  function automatic logic [15:0] quarter_volts(input lin_word_t w);
    logic signed [4:0]  e;
    logic signed [31:0] m;
    logic signed [31:0] q;
    begin
      e = $signed(w[15:11]);
      m = {{21{w[10]}}, w[10:0]};
      q = (e < -2) ? (m >>> (-2 - e)) : (m <<< (e + 2));
      if (q < $signed({16'h0, `TURN_ON_MIN_QV}))      quarter_volts = `TURN_ON_MIN_QV;
      else if (q > $signed({16'h0, `TURN_ON_MAX_QV})) quarter_volts = `TURN_ON_MAX_QV;
      else                                            quarter_volts = q[15:0];
    end
  endfunction : quarter_volts

  // synchronise external status levels
  logic [1:0] en_s_q, above_s_q, low_s_q;
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      en_s_q    <= 2'h0;
      above_s_q <= 2'h0;
      low_s_q   <= 2'h0;
    end
    else
    begin
      en_s_q    <= {en_s_q[0], conv_enable};
      above_s_q <= {above_s_q[0], input_above_on};
      low_s_q   <= {low_s_q[0], low_input_raw};
    end
  end

  // register state
  cfg_state_t  st_q, st_d;
  lin_word_t   freq_reg_q, freq_reg_d;
  lin_word_t   on_reg_q, on_reg_d;
  lin_word_t   floor_q, floor_d;
  lin_word_t   stored_freq_q, stored_freq_d;
  lin_word_t   stored_on_q, stored_on_d;
  logic [10:0] feff_q, feff_d;
  logic [15:0] qv_q, qv_d;
  logic [15:0] rdata_q, rdata_d;
  logic        inval_q, inval_d, alert_q, alert_d;
  logic        mask_q, mask_d, fault_q, fault_d;
  logic [31:0] wr_val, nvm_val;

  // next-state logic; restore reloads hardware even while enabled
  always_comb
  begin
    st_d          = st_q;
    freq_reg_d    = freq_reg_q;
    on_reg_d      = on_reg_q;
    floor_d       = floor_q;
    stored_freq_d = stored_freq_q;
    stored_on_d   = stored_on_q;
    feff_d        = feff_q;
    qv_d          = qv_q;
    rdata_d       = rdata_q;
    inval_d       = 1'b0;
    alert_d       = alert_q;
    mask_d        = mask_q;
    wr_val        = lin_decode(cmd_wdata);
    nvm_val       = lin_decode(nvm_freq);
    case (st_q)
      ST_IDLE: st_d = ST_LOAD;
      ST_LOAD:
      begin
        // exponent rebuilt; mantissa stops at 1023, so larger values use exponent 1
        freq_reg_d    = ($signed(nvm_val) > `FREQ_MAN_MAX) ? {5'h01, nvm_val[11:1]} : {5'h00, nvm_val[10:0]};
        stored_freq_d = nvm_freq;
        on_reg_d      = {`TURN_ON_EXP_RST, nvm_turn_on[10:0]};
        stored_on_d   = {`TURN_ON_EXP_RST, nvm_turn_on[10:0]};
        feff_d        = freq_map(nvm_val);
        qv_d          = quarter_volts({`TURN_ON_EXP_RST, nvm_turn_on[10:0]});
        st_d          = ST_RUN;
      end
      ST_RUN:
      begin
        if (cmd_wr)
        begin
          case (cmd_code)
            `CMD_FLOOR:
            begin
              if (cmd_wdata < ceiling_min || cmd_wdata > ceiling_max)
                inval_d = 1'b1;
              else
                floor_d = cmd_wdata;
            end
            `CMD_FREQ:
            begin
              freq_reg_d = cmd_wdata;
              if (!en_s_q[1])
                feff_d = freq_map(wr_val);
            end
            `CMD_TURN_ON:
            begin
              if ($signed(wr_val) < 0 || wr_val > 32'({16'h0, `TURN_ON_MAX_QV} >> 2))
                inval_d = 1'b1;
              else
              begin
                on_reg_d = cmd_wdata;
                qv_d     = quarter_volts(cmd_wdata);
              end
            end
            `CMD_STORE_ALL:
            begin
              stored_freq_d = freq_reg_q;
              stored_on_d   = on_reg_q;
            end
            `CMD_RESTORE_ALL:
            begin
              freq_reg_d = stored_freq_q;
              on_reg_d   = stored_on_q;
              feff_d     = freq_map(lin_decode(stored_freq_q));
              qv_d       = quarter_volts(stored_on_q);
            end
            default: inval_d = 1'b0;
          endcase
        end
        if (cmd_rd)
        begin
          case (cmd_code)
            `CMD_FLOOR:   rdata_d = floor_q;
            `CMD_FREQ:    rdata_d = freq_reg_q;
            `CMD_TURN_ON: rdata_d = on_reg_q;
            default:      rdata_d = 16'h0000;
          endcase
        end
        // alert holds until the next valid write; set wins
        if (inval_d)
          alert_d = 1'b1;
        else if (cmd_wr)
          alert_d = 1'b0;
      end
      default: st_d = ST_IDLE;
    endcase
    // release mask once input exceeds threshold
    if (above_s_q[1])
      mask_d = 1'b0;
    fault_d = low_s_q[1] & ~mask_q;
  end

  // registers
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      st_q          <= ST_IDLE;
      freq_reg_q    <= 16'h0000;
      on_reg_q      <= {`TURN_ON_EXP_RST, 11'h000};
      floor_q       <= 16'h0000;
      stored_freq_q <= 16'h0000;
      stored_on_q   <= 16'h0000;
      feff_q        <= 11'h0E1;
      qv_q          <= `TURN_ON_MIN_QV;
      rdata_q       <= 16'h0000;
      inval_q       <= 1'b0;
      alert_q       <= 1'b0;
      mask_q        <= 1'b1;
      fault_q       <= 1'b0;
    end
    else
    begin
      st_q          <= st_d;
      freq_reg_q    <= freq_reg_d;
      on_reg_q      <= on_reg_d;
      floor_q       <= floor_d;
      stored_freq_q <= stored_freq_d;
      stored_on_q   <= stored_on_d;
      feff_q        <= feff_d;
      qv_q          <= qv_d;
      rdata_q       <= rdata_d;
      inval_q       <= inval_d;
      alert_q       <= alert_d;
      mask_q        <= mask_d;
      fault_q       <= fault_d;
    end
  end

  // outputs straight from flops
  assign cmd_rdata       = rdata_q;
  assign cmd_invalid     = inval_q;
  assign host_alert      = alert_q;
  assign freq_eff_khz    = feff_q;
  assign turn_on_qv      = qv_q;
  assign low_input_fault = fault_q;

  property p_alert;
    @(posedge ref_clk) disable iff (!rst_n) inval_q |-> alert_q;
  endproperty
  a_alert: assert property (p_alert) else $error("alert missing on invalid data");
  property p_freq_hold;
    @(posedge ref_clk) disable iff (!rst_n)
      (st_q == ST_RUN && cmd_wr && cmd_code == `CMD_FREQ && en_s_q[1]) |=> $stable(feff_q);
  endproperty
  a_freq_hold: assert property (p_freq_hold) else $error("frequency changed while enabled");

  property p_qv_range;
    @(posedge ref_clk) disable iff (!rst_n)
      qv_q >= `TURN_ON_MIN_QV && qv_q <= `TURN_ON_MAX_QV;
  endproperty
  a_qv_range: assert property (p_qv_range) else $error("threshold out of range");

  property p_mask_once;
    @(posedge ref_clk) disable iff (!rst_n) !mask_q |=> !mask_q;
  endproperty
  a_mask_once: assert property (p_mask_once) else $error("mask re-armed");
  property p_masked;
    @(posedge ref_clk) disable iff (!rst_n) $past(mask_q) |-> !fault_q;
  endproperty
  a_masked: assert property (p_masked) else $error("fault while masked");

  // effective frequency lies within the table range, 225 to 1500
  property p_feff_min;
    @(posedge ref_clk) disable iff (!rst_n) feff_q >= 11'd225 && feff_q <= 11'd1500;
  endproperty
  a_feff_min: assert property (p_feff_min) else $error("frequency outside table");

  property p_on_readback;
    @(posedge ref_clk) disable iff (!rst_n)
      (st_q == ST_RUN && cmd_wr && cmd_code == `CMD_TURN_ON && !inval_d) |=> on_reg_q == $past(cmd_wdata);
  endproperty
  a_on_readback: assert property (p_on_readback) else $error("threshold not stored");

  property p_freq_store;
    @(posedge ref_clk) disable iff (!rst_n)
      (st_q == ST_RUN && cmd_wr && cmd_code == `CMD_FREQ) |=> freq_reg_q == $past(cmd_wdata);
  endproperty
  a_freq_store: assert property (p_freq_store) else $error("frequency word lost");
endmodule : freq_and_vin_on_config

/* File: tb/pmbus_host_model.sv */
// host model: word writes and reads on the block's command port
// assumes the block takes a request on a ref_clk edge and answers next cycle
`timescale 1ns/10ps
module pmbus_host_model
(
  // clock
  input  wire logic        ref_clk,
  // command port toward the block
  output logic             cmd_wr,
  output logic             cmd_rd,
  output logic      [7:0]  cmd_code,
  output logic      [15:0] cmd_wdata,
  input  wire logic [15:0] cmd_rdata
);
  // single phase here, so the upper bands stay usable
  localparam bit STACKED = 1'b0;

  // idle lines at time zero
  initial
  begin
    cmd_wr    = 1'b0;
    cmd_rd    = 1'b0;
    cmd_code  = 8'h00;
    cmd_wdata = 16'h0000;
  end

  // one word write; released lines show inverted data, not the old value
  task automatic wr_word(input logic [7:0] code, input logic [15:0] data);
    if (STACKED && code == 8'h33 && data > 16'h044C)
      data = 16'h044C;
    @(posedge ref_clk);
    #1;
    cmd_wr    = 1'b1;
    cmd_code  = code;
    cmd_wdata = data;
    @(posedge ref_clk);
    #1;
    cmd_wr    = 1'b0;
    cmd_code  = ~code;
    cmd_wdata = ~data;
  endtask : wr_word

  // one word read; data is taken after the edge that registers it
  task automatic rd_word(input logic [7:0] code, output logic [15:0] data);
    @(posedge ref_clk);
    #1;
    cmd_rd   = 1'b1;
    cmd_code = code;
    @(posedge ref_clk);
    #1;
    cmd_rd   = 1'b0;
    cmd_code = ~code;
    data     = cmd_rdata;
  endtask : rd_word
endmodule : pmbus_host_model

/* File: tb/test_freq_and_vin_on_config.sv */
// bench: band table, update gating, turn-on rounding, floor range, fault mask
// assumes the host model drives the command port one word at a time
`timescale 1ns/10ps
`include "freq_vin_on_defines.svh"
module test_freq_and_vin_on_config
  import freq_vin_on_pkg::*;
;
  localparam lin_word_t LIM [12] = '{16'h00FA, 16'h012C, 16'h015E, 16'h019A, 16'h01F4, 16'h0258,
                                     16'h02BC, 16'h0334, 16'h03E8, 16'h04B0, 16'h0578, 16'h0672};
  localparam lin_word_t EFF [12] = '{16'h00E1, 16'h0113, 16'h0145, 16'h0177, 16'h01C2, 16'h0226,
                                     16'h028A, 16'h02EE, 16'h0384, 16'h044C, 16'h0514, 16'h05DC};
  localparam lin_word_t TW [5] = '{16'hF028, 16'hE851, 16'h0012, 16'hF049, 16'hF004};
  localparam lin_word_t TQ [5] = '{16'h0028, 16'h0028, 16'h0048, 16'h0049, 16'h000A};
  localparam lin_word_t FW [4] = '{16'h00FF, 16'h0100, 16'h0600, 16'h0601};
  localparam logic      FI [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
  logic        ref_clk, rst_n, cmd_wr, cmd_rd, cmd_invalid, host_alert;
  logic        conv_enable, input_above_on, low_input_raw, low_input_fault;
  logic [7:0]  cmd_code;
  logic [10:0] freq_eff_khz;
  lin_word_t   cmd_wdata, cmd_rdata, nvm_freq, nvm_turn_on, ceiling_min, ceiling_max, turn_on_qv, rd;
  int          num_errors, cmp_count;

  // 25 MHz clock
  initial ref_clk = 1'b0;
  always #20 ref_clk = ~ref_clk;

  pmbus_host_model host (.ref_clk(ref_clk), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code),
                         .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata));
  freq_and_vin_on_config DUT (.ref_clk(ref_clk), .rst_n(rst_n), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_invalid(cmd_invalid),
    .host_alert(host_alert), .nvm_freq(nvm_freq), .nvm_turn_on(nvm_turn_on), .ceiling_min(ceiling_min),
    .ceiling_max(ceiling_max), .conv_enable(conv_enable), .input_above_on(input_above_on),
    .low_input_raw(low_input_raw), .freq_eff_khz(freq_eff_khz), .turn_on_qv(turn_on_qv),
    .low_input_fault(low_input_fault));

  // comparisons, four-state so an unknown never matches
  task automatic chk_word(input lin_word_t got, input lin_word_t exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_flag(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_flag

  // kHz to linear word; the mantissa tops out at 1023, so larger values use exponent 1
  function automatic lin_word_t enc(input lin_word_t khz);
    if (khz > 16'h03FF)
      return {5'h01, khz[11:1]};
    return {5'h00, khz[10:0]};
  endfunction : enc

  // bus helpers; each leaves us just after an edge
  task automatic wrc(input logic [7:0] code, input lin_word_t data, input logic inv);
    host.wr_word(code, data);
    chk_flag(cmd_invalid, inv);
  endtask : wrc
  task automatic rdc(input logic [7:0] code, input lin_word_t exp);
    host.rd_word(code, rd);
    chk_word(rd, exp);
  endtask : rdc
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : idle

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude

  // hang guard
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    conclude();
  end

  // main sequence
  initial
  begin
    {rst_n, conv_enable, input_above_on} = 3'h0;
    low_input_raw = 1'b1;
    nvm_freq      = 16'h0258;
    nvm_turn_on   = 16'hF02A;
    ceiling_min   = 16'h0100;
    ceiling_max   = 16'h0600;
    num_errors    = 0;
    cmp_count     = 0;
    repeat (20) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    idle(3);
    rdc(`CMD_FREQ, 16'h0258);
    chk_word({5'h00, freq_eff_khz}, 16'h028A);
    rdc(`CMD_TURN_ON, 16'hF02A);
    chk_word(turn_on_qv, 16'h002A);
    $display("test reset image done");
    // every band edge, from both sides
    for (int i = 0; i < 12; i++)
    begin
      wrc(`CMD_FREQ, enc(LIM[i] - 16'h0001), 1'b0);
      chk_word({5'h00, freq_eff_khz}, EFF[i]);
      if (i < 11)
      begin
        wrc(`CMD_FREQ, enc(LIM[i]), 1'b0);
        chk_word({5'h00, freq_eff_khz}, EFF[i + 1]);
      end
    end
    wrc(`CMD_FREQ, {5'h01, 11'h0C8}, 1'b0);
    chk_word({5'h00, freq_eff_khz}, 16'h0177);
    wrc(`CMD_FREQ, {5'h1F, 11'h384}, 1'b0);
    chk_word({5'h00, freq_eff_khz}, 16'h01C2);
    $display("test frequency bands done");
    // hardware holds while enabled until store and restore
    conv_enable = 1'b1;
    idle(4);
    wrc(`CMD_FREQ, 16'h0258, 1'b0);
    chk_word({5'h00, freq_eff_khz}, 16'h01C2);
    rdc(`CMD_FREQ, 16'h0258);
    wrc(`CMD_STORE_ALL, 16'h0000, 1'b0);
    wrc(`CMD_RESTORE_ALL, 16'h0000, 1'b0);
    chk_word({5'h00, freq_eff_khz}, 16'h028A);
    conv_enable = 1'b0;
    idle(4);
    wrc(`CMD_FREQ, 16'h0190, 1'b0);
    chk_word({5'h00, freq_eff_khz}, 16'h0177);
    $display("test update gating done");
    for (int i = 0; i < 5; i++)
    begin
      wrc(`CMD_TURN_ON, TW[i], 1'b0);
      chk_word(turn_on_qv, TQ[i]);
      rdc(`CMD_TURN_ON, TW[i]);
    end
    wrc(`CMD_TURN_ON, 16'h0013, 1'b1);
    chk_flag(host_alert, 1'b1);
    rdc(`CMD_TURN_ON, 16'hF004);
    wrc(`CMD_TURN_ON, 16'h07FF, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      wrc(`CMD_FLOOR, FW[i], FI[i]);
      chk_flag(host_alert, FI[i]);
    end
    rdc(`CMD_FLOOR, 16'h0600);
    $display("test turn-on and floor done");
    chk_flag(low_input_fault, 1'b0);
    input_above_on = 1'b1;
    idle(3);
    input_above_on = 1'b0;
    idle(5);
    chk_flag(low_input_fault, 1'b1);
    conv_enable = 1'b1;
    idle(4);
    conv_enable = 1'b0;
    wrc(`CMD_STORE_ALL, 16'h0000, 1'b0);
    wrc(`CMD_RESTORE_ALL, 16'h0000, 1'b0);
    idle(5);
    chk_flag(low_input_fault, 1'b1);
    low_input_raw = 1'b0;
    idle(5);
    chk_flag(low_input_fault, 1'b0);
    $display("test fault mask done");
    // second power-on reset: image above the mantissa limit, fault mask armed again
    nvm_freq      = {5'h01, 11'h28A};
    low_input_raw = 1'b1;
    rst_n         = 1'b0;
    idle(2);
    rst_n         = 1'b1;
    idle(3);
    rdc(`CMD_FREQ, {5'h01, 11'h28A});
    chk_word({5'h00, freq_eff_khz}, 16'h0514);
    chk_flag(low_input_fault, 1'b0);
    $display("test second reset done");
    conclude();
  end
endmodule : test_freq_and_vin_on_config
